/* File: design/dpm_pkg.sv */
package dpm_pkg;

    // register indices on the plain register port
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_PERIOD = 4'h1;
    localparam logic [3:0] A_EV1 = 4'h2;
    localparam logic [3:0] A_EV2 = 4'h3;
    localparam logic [3:0] A_EV3 = 4'h4;
    localparam logic [3:0] A_EV4 = 4'h5;
    localparam logic [3:0] A_TRIG = 4'h6;
    localparam logic [3:0] A_ADJ_A = 4'h7;
    localparam logic [3:0] A_ADJ_B = 4'h8;
    localparam logic [3:0] A_STEP = 4'h9;
    localparam logic [3:0] A_STATUS = 4'hA;

    // field widths
    localparam int WHOLE_W = 14;
    localparam int PH_W = 4;
    localparam int EDGE_W = 18;
    localparam int DUTY_W = 16;
    localparam int TRIG_W = 12;
    localparam int Q_SHIFT = 15;
    localparam int DIV_W = 8;

    localparam logic [15:0] DUTY_FULL = 16'h8000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // usable sub-clock phases per resolution setting
    localparam logic [3:0] RES_MASK_16 = 4'hF;
    localparam logic [3:0] RES_MASK_8 = 4'hE;
    localparam logic [3:0] RES_MASK_4 = 4'hC;
    localparam logic [3:0] RES_MASK_2 = 4'h8;

    typedef enum logic [1:0] {
        DPM_OFF = 2'b00,
        DPM_RESON = 2'b01,
        DPM_MULTI = 2'b10,
        DPM_RSVD = 2'b11
    } dpm_mode_e;

    typedef struct packed {
        logic [14:0] pad;
        logic [2:0] scale;
        logic [3:0] irq_div;
        logic single;
        logic eop;
        logic [1:0] os;
        logic [1:0] res;
        logic hr_dis;
        logic cl_en;
        dpm_mode_e mode;
    } dpm_ctrl_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } dpm_bus_s;

    typedef struct packed {
        logic [15:0] duty;
        logic [17:0] period;
    } dpm_comp_s;

endpackage : dpm_pkg

/* File: design/dpm_irq_div.sv */
`timescale 1ns/1ps
`default_nettype none
module dpm_irq_div import dpm_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic frame_end,
    input wire logic [3:0] div_sel,
    output logic irq
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic irq;
    } dpm_div_s;

    dpm_div_s st_reg;
    dpm_div_s st_next;

    function automatic logic [DIV_W-1:0] div_count(input logic [3:0] s);
        case (s)
            4'h1: div_count = 8'h00;
            4'h2: div_count = 8'h01;
            4'h3: div_count = 8'h03;
            4'h4: div_count = 8'h07;
            4'h5: div_count = 8'h0F;
            4'h6: div_count = 8'h1F;
            4'h7: div_count = 8'h2F;
            4'h8: div_count = 8'h3F;
            4'h9: div_count = 8'h4F;
            4'hA: div_count = 8'h5F;
            4'hB: div_count = 8'h7F;
            4'hC: div_count = 8'h9F;
            4'hD: div_count = 8'hBF;
            4'hE: div_count = 8'hDF;
            4'hF: div_count = 8'hFF;
            default: div_count = 8'h00;
        endcase
    endfunction : div_count

    // setting zero keeps the interrupt silent
    always_comb begin
        st_next = st_reg;
        st_next.irq = 1'b0;
        if (div_sel == 4'h0) begin
            st_next.cnt = '0;
        end else if (frame_end) begin
            if (st_reg.cnt >= div_count(div_sel)) begin
                st_next.cnt = '0;
                st_next.irq = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign irq = st_reg.irq;

endmodule : dpm_irq_div
`default_nettype wire

/* File: design/dpm_edge_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module dpm_edge_ctrl import dpm_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire dpm_bus_s bus,
    output logic [31:0] rdata,
    input wire dpm_comp_s comp,
    input wire logic comp_valid,
    output logic out_a,
    output logic out_b,
    output logic [3:0] a_phase,
    output logic [3:0] b_phase,
    output logic sample_trig,
    output logic frame_end,
    output logic period_irq
);

    typedef struct packed {
        dpm_ctrl_s ctl;
        logic [13:0] period;
        logic [17:0] ev1;
        logic [17:0] ev2;
        logic [17:0] ev3;
        logic [17:0] ev4;
        logic [11:0] trig;
        logic [15:0] adj_a;
        logic [15:0] adj_b;
        logic [15:0] duty;
        logic [15:0] duty_pend;
        logic [17:0] cper;
        logic [17:0] cper_pend;
        logic pend;
        logic halt;
        logic [13:0] cnt;
        logic [13:0] os_cnt;
        logic [2:0] os_left;
        logic a;
        logic b;
        logic trig_o;
        logic fend;
        logic [3:0] a_ph;
        logic [3:0] b_ph;
        logic [31:0] rdata;
    } dpm_st_s;

    logic [1:0] rsync_reg;
    logic rst_n;
    dpm_st_s st_reg;
    dpm_st_s st_next;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rsync_reg <= 2'b00;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end
    assign rst_n = rsync_reg[1];

    function automatic logic [15:0] scale_duty(input logic [15:0] d,
                                               input logic [2:0] s);
        logic [18:0] w;
        w = {3'b000, d};
        case (s)
            3'h1: w = {2'b00, d, 1'b0};
            3'h2: w = {1'b0, d, 2'b00};
            3'h3: w = {d, 3'b000};
            3'h5: w = {4'h0, d[15:1]};
            3'h6: w = {5'h00, d[15:2]};
            3'h7: w = {6'h00, d[15:3]};
            default: w = {3'b000, d};
        endcase
        if (w > {3'b000, DUTY_FULL}) begin
            w = {3'b000, DUTY_FULL};
        end
        return w[15:0];
    endfunction : scale_duty

    logic is_res;
    logic is_multi;
    logic cl;
    logic run;
    logic fe;
    logic [18:0] per_sum;
    logic [17:0] per18;
    logic [13:0] per_w;
    logic [15:0] duty_eff;
    logic [33:0] prod;
    logic [17:0] on;
    logic [18:0] a_fall;
    logic [18:0] b_rise;
    logic [18:0] b_fall;
    logic [18:0] gap;
    logic b_wrap;
    logic [3:0] mask;
    logic hr_on;
    logic trig_hit;
    logic [13:0] spacing;
    logic [15:0] scaled;

    // edge arithmetic, from the values in force this frame
    always_comb begin
        is_res = st_reg.ctl.mode == DPM_RESON;
        is_multi = st_reg.ctl.mode == DPM_MULTI;
        cl = st_reg.ctl.cl_en;
        run = (is_res || is_multi) && !st_reg.halt;
        duty_eff = cl ? st_reg.duty : 16'h0000;
        per_sum = (is_res && cl) ? {1'b0, st_reg.cper}
                                 : {1'b0, st_reg.period, 4'h0};
        if (is_res) begin
            per_sum = per_sum + {{3{st_reg.adj_a[15]}}, st_reg.adj_a};
        end
        per18 = per_sum[18] ? 18'h00000 : per_sum[17:0];
        per_w = per18[17:4];
        prod = {18'h00000, duty_eff} * {16'h0000, per18};
        on = prod[32:15];
        b_wrap = 1'b0;
        gap = '0;
        if (is_res) begin
            a_fall = cl ? {1'b0, st_reg.ev1} + {1'b0, on}
                        : {1'b0, st_reg.ev2};
            gap = {1'b0, st_reg.ev3} - {1'b0, st_reg.ev2};
            b_rise = cl ? a_fall + gap : {1'b0, st_reg.ev3};
            gap = {1'b0, st_reg.period, 4'h0} - {1'b0, st_reg.ev4};
            b_fall = cl ? {1'b0, per18} - gap : {1'b0, st_reg.ev4};
        end else begin
            a_fall = {1'b0, st_reg.ev1} + {1'b0, on}
                   + {{3{st_reg.adj_a[15]}}, st_reg.adj_a};
            b_rise = {1'b0, st_reg.ev3};
            // a negative trim on B is kept valid by software
            b_fall = {1'b0, st_reg.ev3} + {1'b0, on}
                   + {{3{st_reg.adj_b[15]}}, st_reg.adj_b};
            // frame spans whole count plus one clock, so wrap by that
            if (b_fall >= {1'b0, per18} + 19'h00010) begin
                b_fall = b_fall - ({1'b0, per18} + 19'h00010);
                b_wrap = 1'b1;
            end
        end
        case (st_reg.ctl.res)
            2'b00: mask = RES_MASK_16;
            2'b01: mask = RES_MASK_8;
            2'b10: mask = RES_MASK_4;
            2'b11: mask = RES_MASK_2;
            default: mask = RES_MASK_16;
        endcase
        hr_on = !st_reg.ctl.hr_dis;
        fe = run && (st_reg.cnt >= per_w);
        trig_hit = run && (st_reg.cnt == {st_reg.trig, 2'b00});
        spacing = per_w >> st_reg.ctl.os;
        scaled = scale_duty(comp.duty, st_reg.ctl.scale);
    end

    always_comb begin
        st_next = st_reg;
        st_next.trig_o = 1'b0;
        st_next.fend = 1'b0;
        st_next.rdata = '0;

        // period counter and frame stepping
        if (run) begin
            if (fe) begin
                st_next.cnt = '0;
                st_next.fend = 1'b1;
                if (st_reg.ctl.single) begin
                    st_next.halt = 1'b1;
                end
            end else begin
                st_next.cnt = st_reg.cnt + 14'h0001;
            end
        end

        // outputs, whole-count compare plus sub-clock phase
        if (run) begin
            st_next.a = (st_reg.cnt >= st_reg.ev1[17:4])
                     && (st_reg.cnt < a_fall[17:4]);
            if (b_wrap) begin
                st_next.b = (st_reg.cnt >= b_rise[17:4])
                         || (st_reg.cnt < b_fall[17:4]);
            end else begin
                st_next.b = (st_reg.cnt >= b_rise[17:4])
                         && (st_reg.cnt < b_fall[17:4]);
            end
        end else begin
            st_next.a = 1'b0;
            st_next.b = 1'b0;
        end
        st_next.a_ph = '0;
        st_next.b_ph = '0;
        if (hr_on) begin
            st_next.a_ph = a_fall[3:0] & mask;
            if (st_next.b) begin
                st_next.b_ph = b_fall[3:0] & mask;
            end else if (is_res) begin
                st_next.b_ph = b_rise[3:0] & mask;
            end
        end
        if (is_multi && !st_next.b) begin
            st_next.b_ph = '0;
        end

        // sample trigger with oversampling
        if (trig_hit) begin
            st_next.trig_o = 1'b1;
            st_next.os_left = (3'b001 << st_reg.ctl.os) - 3'b001;
            st_next.os_cnt = spacing;
        end else if (run && st_reg.os_left != 3'b000) begin
            if (st_reg.os_cnt <= 14'h0001) begin
                st_next.trig_o = 1'b1;
                st_next.os_left = st_reg.os_left - 3'b001;
                st_next.os_cnt = spacing;
            end else begin
                st_next.os_cnt = st_reg.os_cnt - 14'h0001;
            end
        end

        // compensator values: held to frame end when asked
        if (st_reg.ctl.eop && fe && st_reg.pend) begin
            st_next.duty = st_reg.duty_pend;
            st_next.cper = st_reg.cper_pend;
            st_next.pend = 1'b0;
        end
        if (comp_valid) begin
            if (st_reg.ctl.eop) begin
                st_next.duty_pend = scaled;
                st_next.cper_pend = comp.period;
                st_next.pend = 1'b1;
            end else begin
                st_next.duty = scaled;
                st_next.cper = comp.period;
            end
        end

        // register port
        if (bus.wr) begin
            case (bus.addr)
                A_CTRL: st_next.ctl = bus.wdata;
                A_PERIOD: st_next.period = bus.wdata[13:0];
                A_EV1: st_next.ev1 = bus.wdata[17:0];
                A_EV2: st_next.ev2 = bus.wdata[17:0];
                A_EV3: st_next.ev3 = bus.wdata[17:0];
                A_EV4: st_next.ev4 = bus.wdata[17:0];
                A_TRIG: st_next.trig = bus.wdata[11:0];
                A_ADJ_A: st_next.adj_a = bus.wdata[15:0];
                A_ADJ_B: st_next.adj_b = bus.wdata[15:0];
                // a halt raised in the same cycle survives the step
                A_STEP: st_next.halt = st_next.halt && st_next.fend;
                default: st_next.halt = st_next.halt;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                A_CTRL: st_next.rdata = st_reg.ctl;
                A_PERIOD: st_next.rdata = {18'h00000, st_reg.period};
                A_EV1: st_next.rdata = {14'h0000, st_reg.ev1};
                A_EV2: st_next.rdata = {14'h0000, st_reg.ev2};
                A_EV3: st_next.rdata = {14'h0000, st_reg.ev3};
                A_EV4: st_next.rdata = {14'h0000, st_reg.ev4};
                A_TRIG: st_next.rdata = {20'h00000, st_reg.trig};
                A_ADJ_A: st_next.rdata = {16'h0000, st_reg.adj_a};
                A_ADJ_B: st_next.rdata = {16'h0000, st_reg.adj_b};
                A_STATUS: st_next.rdata = {14'h0000, st_reg.pend,
                    st_reg.halt, st_reg.b, st_reg.a, st_reg.cnt};
                default: st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    dpm_irq_div u_irq (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .frame_end(fe),
        .div_sel(st_reg.ctl.irq_div),
        .irq(period_irq)
    );

    assign rdata = st_reg.rdata;
    assign out_a = st_reg.a;
    assign out_b = st_reg.b;
    assign a_phase = st_reg.a_ph;
    assign b_phase = st_reg.b_ph;
    assign sample_trig = st_reg.trig_o;
    assign frame_end = st_reg.fend;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_WRAP: assert property (
        ce && fe |=> st_reg.cnt == 14'h0000 && st_reg.fend)
        else $error("counter did not wrap at period end");

    AST_TRIG: assert property (
        ce && trig_hit |=> sample_trig)
        else $error("sample trigger missing on count match");

    AST_EOP_HOLD: assert property (
        ce && st_reg.ctl.eop && !fe && !bus.wr |=> $stable(st_reg.duty))
        else $error("compensator value applied mid frame");

    AST_SINGLE: assert property (
        ce && fe && st_reg.ctl.single && !bus.wr
        |=> st_reg.halt ##1 !ce || st_reg.cnt == 14'h0000)
        else $error("single frame did not halt");

    AST_RES2: assert property (
        st_reg.ctl.res == 2'b11 && ce |=> a_phase[2:0] == 3'b000)
        else $error("phase outside two-step resolution");

    AST_HR_OFF: assert property (
        st_reg.ctl.hr_dis && ce && !bus.wr
        |=> a_phase == 4'h0 && b_phase == 4'h0)
        else $error("phase present with high resolution off");

    AST_ON_SAT: assert property (
        on <= per18)
        else $error("on time beyond period");

    AST_MULTI_A: assert property (
        ce && run && is_multi && st_reg.cnt == st_reg.ev1[17:4]
        && a_fall[17:4] > st_reg.ev1[17:4] |=> out_a)
        else $error("multi output A not high at event 1");

    AST_B_FOLLOW: assert property (
        is_res && $rose(out_b) |-> !out_a)
        else $error("resonance B rose while A high");

endmodule : dpm_edge_ctrl
`default_nettype wire

/* File: bench/dpm_comp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpm_comp_model import dpm_pkg::*; (
    input wire logic clock,
    input wire logic sample_trig,
    input wire logic [15:0] duty,
    input wire logic [17:0] period,
    output dpm_comp_s comp,
    output logic comp_valid
);
    logic [2:0] pipe = 3'h0;
    dpm_comp_s comp_reg = '0;
    logic valid_reg = 1'b0;
    // fixed compute latency after each converter start
    always @(posedge clock) begin
        pipe <= {pipe[1:0], sample_trig};
        valid_reg <= pipe[2];
        // value only means something with the strobe, garbage otherwise
        if (pipe[2]) begin
            comp_reg <= '{duty: duty, period: period};
        end else begin
            comp_reg <= ~comp_reg;
        end
    end
    assign comp = comp_reg;
    assign comp_valid = valid_reg;
endmodule : dpm_comp_model
`default_nettype wire

/* File: bench/dpm_edge_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dpm_edge_ctrl_tb import dpm_pkg::*; ();
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    dpm_bus_s bus = '0;
    logic [31:0] rdata;
    logic out_a, out_b, sample_trig, frame_end, period_irq;
    logic [3:0] a_phase, b_phase, pa, pb;
    dpm_comp_s comp;
    logic comp_valid;
    logic [15:0] duty = 16'h4000;
    logic [17:0] cper = 18'h00640;
    int bad_count = 0;
    int checks = 0;
    int len, na, nb, nt, ra, rb, fa, tp;
    dpm_ctrl_s c = '0;
    logic [3:0] msk [4] = '{RES_MASK_16, RES_MASK_8, RES_MASK_4, RES_MASK_2};

    initial forever #4 clock = ~clock;

    dpm_edge_ctrl dut (.clock(clock), .nrst(nrst), .ce(ce), .bus(bus),
        .rdata(rdata), .comp(comp), .comp_valid(comp_valid),
        .out_a(out_a), .out_b(out_b), .a_phase(a_phase), .b_phase(b_phase),
        .sample_trig(sample_trig), .frame_end(frame_end),
        .period_irq(period_irq));
    dpm_comp_model u_comp (.clock(clock), .sample_trig(sample_trig),
        .duty(duty), .period(cper), .comp(comp), .comp_valid(comp_valid));

    task automatic test_done();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : wr

    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata;
        @(posedge clock);
        #1 chk("rdata_idle", 32'h0, rdata);
    endtask : rd

    task automatic wait_fe();
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            #1;
            if (frame_end === 1'b1) return;
        end
        chk("frame_end_wait", 32'h1, 32'h0);
        test_done();
    endtask : wait_fe

    // second frame only: the first may still mix old and new values
    task automatic stats();
        logic qa, qb;
        wait_fe();
        repeat (2) begin
            {len, na, nb, nt, ra, rb, fa} = '0;
            tp = -1;
            pa = '0;
            pb = '0;
            do begin
                {qa, qb} = {out_a, out_b};
                @(posedge clock);
                #1;
                len++;
                if (out_a === 1'b1) na++;
                if (out_b === 1'b1) nb++;
                if (out_a === 1'b1 && qa === 1'b0) ra = len;
                if (out_a === 1'b0 && qa === 1'b1) fa = len;
                if (out_b === 1'b1 && qb === 1'b0) rb = len;
                if (sample_trig === 1'b1) begin
                    nt++;
                    if (tp < 0) tp = len;
                end
                pa |= a_phase;
                pb |= b_phase;
            end while (frame_end !== 1'b1 && len < 3000);
            if (len >= 3000) begin
                chk("frame_wait", 32'h1, 32'h0);
                test_done();
            end
        end
    endtask : stats

    task automatic t_regs();
        logic [31:0] d;
        rd(A_CTRL, d);
        chk("ctrl_reset", CTRL_RST, d);
        wr(A_PERIOD, 32'h0000_0040);
        rd(A_PERIOD, d);
        chk("period", 32'h0000_0040, d);
        rd(4'hB, d);
        chk("unmapped", 32'h0, d);
    endtask : t_regs

    task automatic t_multi();
        c.mode = DPM_MULTI;
        c.cl_en = 1'b1;
        wr(A_TRIG, 32'h5);
        wr(A_EV1, 32'h0);
        wr(A_EV3, 32'h140);
        wr(A_ADJ_A, 32'h0B);
        wr(A_ADJ_B, 32'h43); // adjust kept positive
        for (int k = 0; k < 6; k++) begin
            c.res = k[1:0];
            c.hr_dis = (k > 3);
            wr(A_CTRL, c);
            if (k == 5) wr(A_EV3, 32'h320);
            stats();
            chk("frame_len", 65, len);
            chk("a_width", 32, na);
            chk("b_width", 36, nb);
            chk("a_phase", k > 3 ? 4'h0 : 4'hB & msk[k], pa);
            chk("b_phase", k > 3 ? 4'h0 : 4'h3 & msk[k], pb);
            if (k < 5) chk("b_start", 20, rb - ra);
        end
        c.hr_dis = 1'b0;
        c.res = 2'h0;
    endtask : t_multi

    task automatic t_scale();
        int w [8] = '{16, 32, 64, 64, 16, 8, 4, 2};
        duty = 16'h2000;
        for (int s = 0; s < 8; s++) begin
            c.scale = s[2:0];
            wr(A_CTRL, c);
            stats();
            chk("scaled_width", w[s], na);
        end
        c.scale = 3'h0;
        duty = 16'h4000;
    endtask : t_scale

    task automatic t_os();
        int p;
        for (int s = 0; s < 4; s++) begin
            c.os = s[1:0];
            wr(A_CTRL, c);
            stats();
            chk("trig_count", 1 << s, nt);
        end
        c.os = 2'h0;
        wr(A_CTRL, c);
        wr(A_TRIG, 32'h2);
        stats();
        p = tp;
        wr(A_TRIG, 32'h5);
        stats();
        chk("trig_step", 12, tp - p);
    endtask : t_os

    task automatic irq_gap(output int n);
        n = 0;
        for (int i = 0; i < 5000; i++) begin
            @(posedge clock);
            #1;
            if (frame_end === 1'b1) n++;
            if (period_irq === 1'b1) return;
        end
        chk("irq_wait", 32'h1, 32'h0);
        test_done();
    endtask : irq_gap

    task automatic t_irq();
        int cnt [15] = '{0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127, 159, 191,
            223, 255};
        int n;
        wr(A_PERIOD, 32'h8);
        for (int s = 1; s < 16; s++) begin
            c.irq_div = s[3:0];
            wr(A_CTRL, c);
            irq_gap(n);
            irq_gap(n);
            irq_gap(n);
            chk("irq_frames", cnt[s - 1] + 1, n);
        end
        c.irq_div = 4'h0;
        wr(A_PERIOD, 32'h40);
    endtask : t_irq

    task automatic t_reson();
        c.mode = DPM_RESON;
        wr(A_EV2, 32'hA0);
        wr(A_EV3, 32'hE3);
        wr(A_EV4, 32'h3C6);
        wr(A_ADJ_A, 32'h0);
        wr(A_CTRL, c);
        stats();
        chk("reson_len", 101, len);
        chk("reson_a", 50, na);
        chk("reson_gap", 4, rb - fa);
        chk("reson_b", 42, nb);
        chk("reson_bph", 4'h7, pb);
        wr(A_ADJ_A, 32'h50);
        stats();
        chk("reson_adj_len", 106, len);
    endtask : t_reson

    // new value lands mid frame; held until the frame ends
    task automatic t_eop();
        logic [31:0] d;
        int n;
        c.eop = 1'b1;
        wr(A_CTRL, c);
        wait_fe();
        duty = 16'h2000;
        n = 0;
        repeat (60) begin
            @(posedge clock);
            #1;
            if (out_a === 1'b1) n++;
        end
        chk("eop_old_width", 52, n);
        rd(A_STATUS, d);
        chk("eop_pending", 1, d[17]);
        stats();
        chk("eop_new_width", 26, na);
        c.eop = 1'b0;
        duty = 16'h4000;
    endtask : t_eop

    task automatic t_single();
        logic [31:0] d;
        int n;
        c.single = 1'b1;
        wr(A_CTRL, c);
        wait_fe();
        n = 0;
        repeat (300) begin
            @(posedge clock);
            #1;
            if (frame_end === 1'b1) n++;
        end
        chk("halted_frames", 0, n);
        rd(A_STATUS, d);
        chk("halt_flag", 1, d[16]);
        wr(A_STEP, 32'h0);
        wait_fe();
        rd(A_STATUS, d);
        chk("halt_again", 1, d[16]);
    endtask : t_single

    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (5) @(posedge clock);
        t_regs();
        t_multi();
        t_scale();
        t_os();
        t_irq();
        t_reson();
        t_eop();
        t_single();
        test_done();
    end
endmodule : dpm_edge_ctrl_tb
`default_nettype wire
